// [hdl/seq_core.sv]
// Purpose: Instruction pointer, RAM pointers and table high byte
// Assumes: Decoder gives one command per executed instruction
// Notes:   Register writes and commands in one cycle: register write wins
`timescale 1ns/1ps
module seq_core (
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              reset_n,
   // Sequencer command and table word
   input  wire seq_pkg::seq_cmd_t cmd,
   input  wire logic [15:0]       table_word,
   // Register port
   input  wire seq_pkg::reg_req_t req,
   output logic [7:0]             rdata,
   // Addresses and table low byte out
   output logic [9:0]             fetch_addr,
   output logic [15:0]            ram_addr,
   output logic [15:0]            table_addr,
   output logic [7:0]             table_low_byte,
   output logic                   table_low_valid
);

   // ****************************************
   // State
   // ****************************************
   logic [9:0]  ip_r,     ip_nxt;
   logic [7:0]  thb_r,    thb_nxt;
   logic [7:0]  roff_r,   roff_nxt;
   logic [7:0]  rbank_r,  rbank_nxt;
   logic [7:0]  rdata_r,  rdata_nxt;
   logic [7:0]  tlow_r,   tlow_nxt;
   logic        tval_r,   tval_nxt;
   logic        skip;
   logic [8:0]  low_sum;

   skip_eval i_skip_eval (
      .cmd  (cmd),
      .skip (skip)
   );

   function automatic logic [7:0] read_mux(input logic [7:0] a, input logic [9:0] ip,
                                           input logic [7:0] t, input logic [7:0] o,
                                           input logic [7:0] b);
      case (a)
         seq_pkg::ADDR_TABLE_HIGH: read_mux = t;
         seq_pkg::ADDR_RAM_OFFSET: read_mux = o;
         seq_pkg::ADDR_RAM_BANK:   read_mux = b;
         seq_pkg::ADDR_IP_LOW:     read_mux = ip[7:0];
         seq_pkg::ADDR_IP_HIGH:    read_mux = {6'h00, ip[9:8]};
         default:                  read_mux = 8'h00;
      endcase
   endfunction

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      ip_nxt    = ip_r;
      thb_nxt   = thb_r;
      roff_nxt  = roff_r;
      rbank_nxt = rbank_r;
      tlow_nxt  = tlow_r;
      tval_nxt  = 1'b0;
      rdata_nxt = req.rd ? read_mux(req.addr, ip_r, thb_r, roff_r, rbank_r) : 8'h00;
      low_sum   = 9'(ip_r[7:0]) + 9'(cmd.add_value) + 9'(cmd.add_carry_in);
      if (cmd.exec) begin
         case (cmd.op)
            seq_pkg::OP_JUMP:   ip_nxt = cmd.target;
            // Carry only ever moves the high part up; no borrow path
            seq_pkg::OP_IPL_ADD: ip_nxt = {ip_r[9:8] + {1'b0, low_sum[8]},
                                           low_sum[7:0]};
            seq_pkg::OP_TABLE_READ: begin
               thb_nxt  = table_word[15:8];
               tlow_nxt = table_word[7:0];
               tval_nxt = 1'b1;
               ip_nxt   = ip_r + seq_pkg::IP_STEP;
            end
            default: begin
               // Ten-bit sum wraps naturally past the top word
               ip_nxt = ip_r + (skip ? seq_pkg::IP_SKIP_STEP
                                     : seq_pkg::IP_STEP);
            end
         endcase
      end
      if (req.wr) begin
         case (req.addr)
            seq_pkg::ADDR_TABLE_HIGH: thb_nxt   = req.wdata;
            seq_pkg::ADDR_RAM_OFFSET: roff_nxt  = req.wdata;
            seq_pkg::ADDR_RAM_BANK:   rbank_nxt = req.wdata;
            seq_pkg::ADDR_IP_LOW:     ip_nxt    = {ip_r[9:8], req.wdata};
            seq_pkg::ADDR_IP_HIGH:    ip_nxt    = {req.wdata[1:0], ip_r[7:0]};
            default:                  ;
         endcase
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ip_r    <= seq_pkg::IP_RESET;
         rdata_r <= 8'h00;
         tval_r  <= 1'b0;
         tlow_r  <= 8'h00;
      end else begin
         ip_r    <= ip_nxt;
         rdata_r <= rdata_nxt;
         tval_r  <= tval_nxt;
         tlow_r  <= tlow_nxt;
      end
   end

   // Left unreset on purpose: contents undefined until written
   always_ff @(posedge clk_sys) begin
      thb_r   <= thb_nxt;
      roff_r  <= roff_nxt;
      rbank_r <= rbank_nxt;
   end

   assign rdata           = rdata_r;
   assign fetch_addr      = ip_r;
   assign ram_addr        = {rbank_r, roff_r};
   assign table_addr      = {rbank_r, roff_r};
   assign table_low_byte  = tlow_r;
   assign table_low_valid = tval_r;

endmodule

// [hdl/seq_pkg.sv]
// Purpose: Constants and types for the instruction sequencing block
// Assumes: One core clock, asynchronous active-low reset
// Notes:   Register offsets are byte addresses on the plain register port
//
// Behaviour
// - Ten-bit pointer, two-bit high, eight-bit low
// - Sequential execution advances pointer by one
// - Call or jump loads ten-bit destination
// - True skip condition advances pointer by two
// - Bit test skips when bit matches form
// - Compare skips when accumulator equals operand
// - Increment skip only on 0xFF to 0x00
// - Decrement skip only on 0x01 to 0x00
// - Inc/dec skip decided on written result
// - Adds into low byte carry to high
// - Borrow from low byte leaves high unchanged
// - Move into low byte keeps high page
// - Two eight-bit read/write pointer registers
// - Indirect port address is bank and offset
// - Table read addresses program memory by pointers
// - Table read: high byte to register, low to accumulator
// - Eight-bit read/write table high byte register
package seq_pkg;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] ADDR_TABLE_HIGH  = 8'h82;
   localparam logic [7:0] ADDR_RAM_OFFSET  = 8'h83;
   localparam logic [7:0] ADDR_RAM_BANK    = 8'h84;
   localparam logic [7:0] ADDR_IP_LOW      = 8'hCE;
   localparam logic [7:0] ADDR_IP_HIGH     = 8'hCF;

   // ****************************************
   // Widths and reset values
   // ****************************************
   localparam int         IP_W             = 10;
   localparam int         IP_HIGH_W        = 2;
   localparam logic [9:0] IP_RESET         = 10'h000;
   localparam logic [9:0] IP_STEP          = 10'h001;
   localparam logic [9:0] IP_SKIP_STEP     = 10'h002;
   localparam logic [7:0] INC_WRAP_RESULT  = 8'h00;
   localparam logic [7:0] DEC_WRAP_RESULT  = 8'h00;

   // ****************************************
   // Operation classes from the decoder
   // ****************************************
   typedef enum logic [3:0] {
      OP_NONE       = 4'h0,
      OP_SEQ        = 4'h1,
      OP_JUMP       = 4'h3,
      OP_CMP_SKIP   = 4'h2,
      OP_INC_SKIP   = 4'h6,
      OP_DEC_SKIP   = 4'h7,
      OP_BIT0_SKIP  = 4'h5,
      OP_BIT1_SKIP  = 4'h4,
      OP_IPL_ADD    = 4'hC,
      OP_TABLE_READ = 4'hD
   } op_t;

   // Sequencer command issued once per executed instruction
   typedef struct packed {
      logic       exec;
      op_t        op;
      logic [9:0] target;
      logic [7:0] acc;
      logic [7:0] operand;
      logic [7:0] result;
      logic       tested_bit;
      logic [7:0] add_value;
      logic       add_carry_in;
   } seq_cmd_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

endpackage

// [hdl/skip_eval.sv]
// Purpose: Decides whether a skip-capable operation skips the next word
// Assumes: Result already computed by the datapath
// Notes:   Purely combinational
`timescale 1ns/1ps
module skip_eval (
   // Command
   input  wire seq_pkg::seq_cmd_t cmd,
   // Decision
   output logic                   skip
);
   always_comb begin
      case (cmd.op)
         seq_pkg::OP_CMP_SKIP:  skip = (cmd.acc == cmd.operand);
         seq_pkg::OP_INC_SKIP:  skip = (cmd.result == seq_pkg::INC_WRAP_RESULT);
         seq_pkg::OP_DEC_SKIP:  skip = (cmd.result == seq_pkg::DEC_WRAP_RESULT)
                                      && (cmd.operand != seq_pkg::DEC_WRAP_RESULT);
         seq_pkg::OP_BIT0_SKIP: skip = !cmd.tested_bit;
         seq_pkg::OP_BIT1_SKIP: skip = cmd.tested_bit;
         default:               skip = 1'b0;
      endcase
   end
endmodule

// [bench/seq_core_chk.sv]
// Purpose: Port assertions for the sequencer
// Assumes: Bound onto seq_core
// Notes:   Commands gated on no register write, which wins
`timescale 1ns/1ps
module seq_core_chk (
   // Clock and reset
   input wire logic              clk_sys,
   input wire logic              reset_n,
   // Watched ports
   input wire seq_pkg::seq_cmd_t cmd,
   input wire logic [15:0]       table_word,
   input wire seq_pkg::reg_req_t req,
   input wire logic [9:0]        fetch_addr,
   input wire logic [7:0]        table_low_byte,
   input wire logic              table_low_valid
);
   seq_pkg::seq_cmd_t c_r;
   seq_pkg::reg_req_t q_r;
   logic [9:0]        pa_r;
   always_ff @(posedge clk_sys) begin
      c_r <= cmd;
      q_r <= req;
      pa_r <= fetch_addr;
   end
   wire [9:0] dlt = fetch_addr - pa_r;
   wire [8:0] sum = pa_r[7:0] + c_r.add_value + c_r.add_carry_in;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   sequence s_go; cmd.exec && !req.wr; endsequence
   property p_seq; s_go ##0 cmd.op == seq_pkg::OP_SEQ |=> dlt == 10'h001; endproperty
   property p_jump; s_go ##0 cmd.op == seq_pkg::OP_JUMP |=> fetch_addr == c_r.target; endproperty
   property p_cmp; s_go ##0 cmd.op == seq_pkg::OP_CMP_SKIP
      |=> dlt == (c_r.acc == c_r.operand ? 10'h002 : 10'h001); endproperty
   property p_inc; s_go ##0 cmd.op == seq_pkg::OP_INC_SKIP
      |=> dlt == (c_r.operand == 8'hFF ? 10'h002 : 10'h001); endproperty
   property p_dec; s_go ##0 cmd.op == seq_pkg::OP_DEC_SKIP
      |=> dlt == (c_r.operand == 8'h01 ? 10'h002 : 10'h001); endproperty
   property p_bit; s_go ##0 cmd.op == seq_pkg::OP_BIT0_SKIP
      |=> dlt == (c_r.tested_bit ? 10'h001 : 10'h002); endproperty
   property p_bit1; s_go ##0 cmd.op == seq_pkg::OP_BIT1_SKIP
      |=> dlt == (c_r.tested_bit ? 10'h002 : 10'h001); endproperty
   property p_add; s_go ##0 cmd.op == seq_pkg::OP_IPL_ADD
      |=> fetch_addr == {pa_r[9:8] + {1'b0, sum[8]}, sum[7:0]}; endproperty
   property p_low; req.wr && req.addr == seq_pkg::ADDR_IP_LOW
      |=> fetch_addr == {pa_r[9:8], q_r.wdata}; endproperty
   property p_tbl; s_go ##0 cmd.op == seq_pkg::OP_TABLE_READ
      |=> table_low_valid && table_low_byte == $past(table_word[7:0]); endproperty
   a_seq: assert property (p_seq) else $error("step not one");
   a_jump: assert property (p_jump) else $error("jump target lost");
   a_cmp: assert property (p_cmp) else $error("compare skip wrong");
   a_inc: assert property (p_inc) else $error("increment skip wrong");
   a_dec: assert property (p_dec) else $error("decrement skip wrong");
   a_bit: assert property (p_bit) else $error("bit skip wrong");
   a_bit1: assert property (p_bit1) else $error("bit one skip wrong");
   a_add: assert property (p_add) else $error("low add carry wrong");
   a_low: assert property (p_low) else $error("low write moved page");
   a_tbl: assert property (p_tbl) else $error("table low byte wrong");
endmodule

// [bench/decode_model.sv]
// Purpose: Decoder and datapath stand-in for the sequencer
// Assumes: One command per call, exec for one cycle
// Notes:   Program memory is a fixed scramble of its address
`timescale 1ns/1ps
module decode_model (
   // Clock
   input  wire logic         clk_sys,
   // Command and program word
   output seq_pkg::seq_cmd_t cmd,
   output logic [15:0]       table_word,
   // Table address
   input  wire logic [15:0]  table_addr
);
   assign table_word = {~table_addr[7:0], table_addr[15:8]};
   initial cmd = '0;
   task issue(input seq_pkg::seq_cmd_t c);
      @(posedge clk_sys);
      cmd <= c;
      @(posedge clk_sys);
      cmd.exec <= 1'b0;
   endtask
endmodule

// [bench/seq_core_bench.sv]
// Purpose: Self-checking bench for the sequencer
// Assumes: 25 MHz clock, datapath computes inc/dec results
// Notes:   Expected pointer kept in ip
`timescale 1ns/1ps
module seq_core_bench;
   logic              clk_sys = 1'b0;
   logic              reset_n = 1'b0;
   seq_pkg::seq_cmd_t cmd;
   seq_pkg::reg_req_t req = '0;
   logic [15:0]       table_word, ram_addr, table_addr;
   logic [7:0]        rdata, table_low_byte;
   logic [9:0]        fetch_addr, ip;
   logic              table_low_valid;
   int                mismatches = 0;
   int                checked = 0;
   always #20 clk_sys = ~clk_sys;
   decode_model i_decode_model (.clk_sys(clk_sys), .cmd(cmd), .table_word(table_word),
      .table_addr(table_addr));
   seq_core i_seq_core (.clk_sys(clk_sys), .reset_n(reset_n), .cmd(cmd), .req(req),
      .table_word(table_word), .rdata(rdata), .fetch_addr(fetch_addr), .ram_addr(ram_addr),
      .table_addr(table_addr), .table_low_byte(table_low_byte),
      .table_low_valid(table_low_valid));
   task cmp(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      req <= '{1'b1, 1'b0, a, d};
      @(posedge clk_sys);
      req.wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk_sys);
      req.rd <= 1'b0;
      #1 cmp(rdata, e);
   endtask
   // Operand drives inc/dec result, a[0] drives tested bit; jump and add take d as absolute
   task step(input logic [3:0] o, input logic [7:0] a, input logic [7:0] p,
      input logic [9:0] d);
      seq_pkg::op_t op;
      op = seq_pkg::op_t'(o);
      i_decode_model.issue('{1'b1, op, d, a, p, (o[0] ? p - 8'h01 : p + 8'h01), a[0], a, 1'b0});
      #1 ip = (op inside {seq_pkg::OP_JUMP, seq_pkg::OP_IPL_ADD}) ? d : ip + d;
      cmp(fetch_addr, ip);
   endtask
   task complete_run;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      repeat (5) @(posedge clk_sys);
      reset_n <= 1'b1;
      ip = 10'h000;
      #1 cmp(fetch_addr, ip);
      step(4'h1, 8'h00, 8'h00, 10'h001);
      step(4'h2, 8'h12, 8'h12, 10'h002);
      step(4'h2, 8'h12, 8'h13, 10'h001);
      step(4'h6, 8'h00, 8'hFF, 10'h002);
      step(4'h6, 8'h00, 8'h00, 10'h001);
      step(4'h7, 8'h00, 8'h01, 10'h002);
      step(4'h7, 8'h00, 8'h00, 10'h001);
      step(4'h5, 8'h00, 8'h00, 10'h002);
      step(4'h5, 8'h01, 8'h00, 10'h001);
      step(4'h4, 8'h01, 8'h00, 10'h002);
      step(4'h4, 8'h00, 8'h00, 10'h001);
      step(4'h3, 8'h00, 8'h00, 10'h3FF);
      step(4'h2, 8'h05, 8'h05, 10'h002);
      $display("test skip done");
      wr(8'hCF, 8'h01);
      wr(8'hCE, 8'hFE);
      #1 cmp(fetch_addr, 16'h01FE);
      ip = 10'h1FE;
      step(4'hC, 8'h05, 8'h00, 10'h203);
      $display("test page done");
      wr(8'h82, 8'hA5);
      wr(8'h83, 8'h34);
      wr(8'h84, 8'h12);
      rd(8'h82, 8'hA5);
      rd(8'h83, 8'h34);
      rd(8'h84, 8'h12);
      rd(8'h90, 8'h00);
      cmp(ram_addr, 16'h1234);
      cmp(table_addr, 16'h1234);
      step(4'hD, 8'h00, 8'h00, 10'h001);
      cmp(table_low_byte, 8'h12);
      cmp(table_low_valid, 16'h0001);
      rd(8'h82, 8'hCB);
      wr(8'hCE, 8'h00);
      #1 cmp(fetch_addr, 16'h0200);
      $display("test pointers done");
      complete_run;
   end
   initial begin
      #20000;
      mismatches++;
      complete_run;
   end
endmodule
bind seq_core seq_core_chk i_seq_core_chk (.clk_sys(clk_sys), .reset_n(reset_n), .cmd(cmd),
   .table_word(table_word), .req(req), .fetch_addr(fetch_addr),
   .table_low_byte(table_low_byte), .table_low_valid(table_low_valid));
